// ### verilog/nims_params.svh
// Register offsets, field positions and timing counts of the interrupt block
`ifndef NIMS_PARAMS_SVH
`define NIMS_PARAMS_SVH

`define NIMS_FLAG_OFFSET 8'h14
`define NIMS_ENABLE_OFFSET 8'h18
`define NIMS_CONFIG_OFFSET 8'h1C
`define NIMS_STATE_OFFSET 8'h20
`define NIMS_FLAG_MASK 16'h7fff
`define NIMS_FLAG_RESET 16'h0000
`define NIMS_ENABLE_RESET 16'h0000
`define NIMS_CONFIG_RESET 2'b00
`define NIMS_BIT_BUS_RETRY 14
`define NIMS_BIT_HEARTBEAT 13
`define NIMS_BIT_FILTER_LOAD 12
`define NIMS_BIT_DESC_REQUEST 11
`define NIMS_BIT_RX_PACKET 10
`define NIMS_BIT_TX_DONE 9
`define NIMS_BIT_TX_FAULT 8
`define NIMS_BIT_TIMER_WRAP 7
`define NIMS_BIT_RX_DESC_EMPTY 6
`define NIMS_BIT_RX_RESOURCE_EMPTY 5
`define NIMS_BIT_RX_AREA_END 4
`define NIMS_BIT_CHECKSUM_TALLY 3
`define NIMS_BIT_ALIGN_TALLY 2
`define NIMS_BIT_MISSED_TALLY 1
`define NIMS_BIT_RX_OVERFLOW 0
`define NIMS_CFG_LATCHED_RETRY 0
`define NIMS_CFG_SOFT_RESET 1
`define NIMS_CLK_PERIOD_PS 4000
`define NIMS_HEARTBEAT_WINDOW_PS 6400000
`define NIMS_HEARTBEAT_CYCLES ((`NIMS_HEARTBEAT_WINDOW_PS) / (`NIMS_CLK_PERIOD_PS))

`endif

// ### verilog/nims_pkg.sv
// Types shared by the interrupt block
`default_nettype none
package nims_pkg;
  typedef enum logic [1:0] {
    NIMS_HB_IDLE = 2'b00,
    NIMS_HB_WATCH = 2'b01,
    NIMS_HB_SEEN = 2'b10
  } nims_hb_state_t;

  typedef enum logic [1:0] {
    NIMS_WR_IDLE = 2'b00,
    NIMS_WR_RESP = 2'b01
  } nims_wr_state_t;
endpackage
`default_nettype wire

// ### verilog/nims_heartbeat_watch.sv
// Heartbeat watch window after each transmission
`timescale 1ns/1ps
`include "nims_params.svh"
`default_nettype none
module nims_heartbeat_watch
  import nims_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tx_end,
  input wire logic collision_pulse,
  output logic heartbeat_missing
);
  localparam logic [10:0] WINDOW = 11'(`NIMS_HEARTBEAT_CYCLES);

  typedef struct packed {
    nims_hb_state_t st;
    logic [10:0] cnt;
    logic miss;
  } nims_hb_t;

  nims_hb_t s_q;
  nims_hb_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.miss = 1'b0;
    unique case (s_q.st)
      NIMS_HB_IDLE: begin
        if (tx_end) begin
          s_d.st = NIMS_HB_WATCH;
          s_d.cnt = WINDOW;
        end
      end
      NIMS_HB_WATCH: begin
        if (collision_pulse) begin
          s_d.st = NIMS_HB_SEEN;
        end else if (s_q.cnt == 11'h001) begin
          s_d.miss = 1'b1;
          s_d.st = NIMS_HB_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 11'h001;
        end
      end
      NIMS_HB_SEEN: begin
        s_d.st = NIMS_HB_IDLE;
      end
      default: begin
        s_d.st = NIMS_HB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign heartbeat_missing = s_q.miss;

  property p_hb_window;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.st == NIMS_HB_IDLE && tx_end) ##1 (!collision_pulse)[*2]
      |-> !s_q.miss;
  endproperty
  a_hb_window: assert property (p_hb_window) else $error("heartbeat miss too early");
endmodule
`default_nettype wire

// ### verilog/nims_axil_slave.sv
// AXI4-Lite slave front end for the interrupt registers
`timescale 1ns/1ps
`include "nims_params.svh"
`default_nettype none
module nims_axil_slave
  import nims_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw;
    logic w_have;
    logic [31:0] w;
    logic [3:0] ws;
    nims_wr_state_t wst;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } nims_bus_t;

  nims_bus_t s_q;
  nims_bus_t s_d;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic fire;

  always_comb begin
    aw_take = s_axi_awvalid && s_q.awrdy;
    w_take = s_axi_wvalid && s_q.wrdy;
    ar_take = s_axi_arvalid && s_q.arrdy;
    s_d = s_q;
    if (aw_take) begin
      s_d.aw_have = 1'b1;
      s_d.aw = s_axi_awaddr;
    end
    if (w_take) begin
      s_d.w_have = 1'b1;
      s_d.w = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    fire = s_q.aw_have && s_q.w_have && s_q.wst == NIMS_WR_IDLE;
    if (fire) begin
      s_d.wst = NIMS_WR_RESP;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok ? 2'b00 : 2'b10;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.wst = NIMS_WR_IDLE;
    end
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_ok ? rd_data : 32'h0000_0000;
      s_d.rresp = rd_ok ? 2'b00 : 2'b10;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // Readies from flops; low for one edge after reset
    s_d.awrdy = !s_d.aw_have && s_d.wst == NIMS_WR_IDLE;
    s_d.wrdy = !s_d.w_have && s_d.wst == NIMS_WR_IDLE;
    s_d.arrdy = !s_d.rvalid;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign wr_stb = fire;
  assign wr_addr = s_q.aw;
  assign wr_data = s_q.w;
  assign wr_strb = s_q.ws;
  assign rd_addr = s_axi_araddr;
endmodule
`default_nettype wire

// ### verilog/nims_irq_ctrl.sv
// Interrupt flag and enable registers with the interrupt pin
`timescale 1ns/1ps
`include "nims_params.svh"
`default_nettype none
module nims_irq_ctrl
  import nims_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_retry_input,
  input wire logic bus_master,
  input wire logic tx_end,
  input wire logic collision_pulse,
  input wire logic filter_load_done,
  input wire logic tx_desc_request,
  input wire logic rx_seq_written,
  input wire logic tx_status_written,
  input wire logic tx_list_end,
  input wire logic tx_halted,
  input wire logic byte_total_mismatch,
  input wire logic too_many_collisions,
  input wire logic tx_fifo_underrun,
  input wire logic deferral_overlimit,
  input wire logic timer_wrap,
  input wire logic rx_desc_empty,
  input wire logic rx_resource_empty,
  input wire logic rx_area_end,
  input wire logic checksum_tally_wrap,
  input wire logic align_tally_wrap,
  input wire logic missed_tally_wrap,
  input wire logic rx_overflow,
  output logic irq,
  output logic dma_hold,
  output logic soft_reset
);
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] enables;
    logic [1:0] cfg;
    logic irq;
    logic hold;
    logic [7:0] tx_cause;
  } nims_core_t;

  nims_core_t s_q;
  nims_core_t s_d;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic heartbeat_missing;
  logic [15:0] events;
  logic [15:0] clear;
  logic tx_abort;

  nims_axil_slave u_bus (
    .mclk(mclk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  nims_heartbeat_watch u_hb (
    .mclk(mclk),
    .reset_n(reset_n),
    .tx_end(tx_end),
    .collision_pulse(collision_pulse),
    .heartbeat_missing(heartbeat_missing)
  );

  // Address decode; unmapped answers SLVERR
  always_comb begin
    wr_ok = (wr_addr == `NIMS_FLAG_OFFSET) || (wr_addr == `NIMS_ENABLE_OFFSET)
      || (wr_addr == `NIMS_CONFIG_OFFSET);
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `NIMS_FLAG_OFFSET: rd_data = {16'h0000, s_q.flags};
      `NIMS_ENABLE_OFFSET: rd_data = {16'h0000, s_q.enables};
      `NIMS_CONFIG_OFFSET: rd_data = {30'h0000_0000, s_q.cfg};
      `NIMS_STATE_OFFSET: rd_data = {23'h00_0000, s_q.hold, s_q.tx_cause};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    tx_abort = byte_total_mismatch | too_many_collisions | tx_fifo_underrun
      | deferral_overlimit;
    events = 16'h0000;
    events[`NIMS_BIT_BUS_RETRY] = bus_retry_input
      & (bus_master | ~s_q.cfg[`NIMS_CFG_LATCHED_RETRY]);
    events[`NIMS_BIT_HEARTBEAT] = heartbeat_missing;
    events[`NIMS_BIT_FILTER_LOAD] = filter_load_done;
    events[`NIMS_BIT_DESC_REQUEST] = tx_desc_request;
    events[`NIMS_BIT_RX_PACKET] = rx_seq_written;
    events[`NIMS_BIT_TX_DONE] = tx_status_written
      & (tx_list_end | tx_halted | tx_abort);
    events[`NIMS_BIT_TX_FAULT] = tx_status_written & tx_abort;
    events[`NIMS_BIT_TIMER_WRAP] = timer_wrap;
    events[`NIMS_BIT_RX_DESC_EMPTY] = rx_desc_empty;
    events[`NIMS_BIT_RX_RESOURCE_EMPTY] = rx_resource_empty;
    events[`NIMS_BIT_RX_AREA_END] = rx_area_end;
    events[`NIMS_BIT_CHECKSUM_TALLY] = checksum_tally_wrap;
    events[`NIMS_BIT_ALIGN_TALLY] = align_tally_wrap;
    events[`NIMS_BIT_MISSED_TALLY] = missed_tally_wrap;
    events[`NIMS_BIT_RX_OVERFLOW] = rx_overflow;

    s_d = s_q;
    clear = 16'h0000;
    if (wr_stb && wr_addr == `NIMS_FLAG_OFFSET) begin
      clear = wr_data[15:0] & {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    end
    if (wr_stb && wr_addr == `NIMS_ENABLE_OFFSET) begin
      if (wr_strb[0]) begin
        s_d.enables[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        s_d.enables[15:8] = wr_data[15:8] & 8'h7f;
      end
    end
    if (wr_stb && wr_addr == `NIMS_CONFIG_OFFSET && wr_strb[0]) begin
      s_d.cfg = wr_data[1:0];
    end
    s_d.flags = ((s_q.flags & ~clear) | events) & `NIMS_FLAG_MASK;
    if (tx_status_written) begin
      s_d.tx_cause = {4'h0, deferral_overlimit, tx_fifo_underrun, too_many_collisions,
        byte_total_mismatch};
    end
    // latched retry suspends DMA
    // New mode applies with the write, no lag
    if (s_d.cfg[`NIMS_CFG_LATCHED_RETRY]) begin
      s_d.hold = s_d.flags[`NIMS_BIT_BUS_RETRY];
    end else begin
      s_d.hold = 1'b0;
    end
    s_d.irq = |(s_d.flags & s_d.enables);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq = s_q.irq;
  assign dma_hold = s_q.hold;
  assign soft_reset = s_q.cfg[`NIMS_CFG_SOFT_RESET];

  property p_enable_reserved;
    @(posedge mclk) disable iff (!reset_n) s_q.enables[15] == 1'b0;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved) else $error("enable bit 15 set");

  property p_masked_quiet;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.flags != 16'h0000 && (s_q.flags & s_q.enables) == 16'h0000) |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq without enabled flag");

  property p_irq_tracks;
    @(posedge mclk) disable iff (!reset_n) irq == |(s_q.flags & s_q.enables);
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("irq mismatch");

  property p_set_wins;
    @(posedge mclk) disable iff (!reset_n) (events != 16'h0000) |=> ((s_q.flags & $past(events)) == $past(events));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_clear_one;
    @(posedge mclk) disable iff (!reset_n)
      (clear[`NIMS_BIT_RX_OVERFLOW] && !events[`NIMS_BIT_RX_OVERFLOW]) |=> !s_q.flags[`NIMS_BIT_RX_OVERFLOW];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

  property p_zero_keeps;
    @(posedge mclk) disable iff (!reset_n) (s_q.flags & ~clear) != 16'h0000 |=> ((s_q.flags & $past(s_q.flags & ~clear)) == $past(s_q.flags & ~clear));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero write");

  property p_retry_latched;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.cfg[`NIMS_CFG_LATCHED_RETRY] && bus_retry_input && !bus_master && !s_q.flags[14]) |=> !s_q.flags[14];
  endproperty
  a_retry_latched: assert property (p_retry_latched) else $error("retry set without mastership");

  property p_hold_latched;
    @(posedge mclk) disable iff (!reset_n) (s_q.cfg[0] && s_q.flags[14]) |-> dma_hold;
  endproperty
  a_hold_latched: assert property (p_hold_latched) else $error("DMA not held");

  property p_txdone_status;
    @(posedge mclk) disable iff (!reset_n) (!s_q.flags[9] && !tx_status_written) |=> !s_q.flags[9];
  endproperty
  a_txdone_status: assert property (p_txdone_status) else $error("tx done early");

  // Host write that releases a latched retry hold
  sequence s_retry_clear;
    wr_stb && wr_addr == `NIMS_FLAG_OFFSET && wr_strb[1]
      && wr_data[`NIMS_BIT_BUS_RETRY] && !events[`NIMS_BIT_BUS_RETRY];
  endsequence

  sequence s_status_abort;
    tx_status_written && tx_abort;
  endsequence

  property p_hold_release;
    @(posedge mclk) disable iff (!reset_n) s_retry_clear |=> !dma_hold;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold stuck");

  property p_unlatched_free;
    @(posedge mclk) disable iff (!reset_n)
      !s_q.cfg[`NIMS_CFG_LATCHED_RETRY] |-> !dma_hold;
  endproperty
  a_unlatched_free: assert property (p_unlatched_free) else $error("hold unlatched");

  property p_retry_master;
    @(posedge mclk) disable iff (!reset_n)
      (bus_retry_input && bus_master) |=> s_q.flags[`NIMS_BIT_BUS_RETRY];
  endproperty
  a_retry_master: assert property (p_retry_master) else $error("retry flag missed");

  property p_heartbeat_flag;
    @(posedge mclk) disable iff (!reset_n)
      heartbeat_missing |=> s_q.flags[`NIMS_BIT_HEARTBEAT];
  endproperty
  a_heartbeat_flag: assert property (p_heartbeat_flag) else $error("heartbeat flag missed");

  property p_desc_request;
    @(posedge mclk) disable iff (!reset_n)
      (!s_q.flags[`NIMS_BIT_DESC_REQUEST] && !tx_desc_request)
      |=> !s_q.flags[`NIMS_BIT_DESC_REQUEST];
  endproperty
  a_desc_request: assert property (p_desc_request) else $error("request flag unprompted");

  property p_rx_packet;
    @(posedge mclk) disable iff (!reset_n)
      (!s_q.flags[`NIMS_BIT_RX_PACKET] && !rx_seq_written) |=> !s_q.flags[`NIMS_BIT_RX_PACKET];
  endproperty
  a_rx_packet: assert property (p_rx_packet) else $error("rx flag early");

  property p_done_causes;
    @(posedge mclk) disable iff (!reset_n)
      (tx_status_written && (tx_list_end || tx_halted)) |=> s_q.flags[`NIMS_BIT_TX_DONE];
  endproperty
  a_done_causes: assert property (p_done_causes) else $error("tx done missed");

  property p_fault_set;
    @(posedge mclk) disable iff (!reset_n)
      s_status_abort |=> s_q.flags[`NIMS_BIT_TX_FAULT] && s_q.flags[`NIMS_BIT_TX_DONE];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("tx fault missed");

  property p_fault_clean;
    @(posedge mclk) disable iff (!reset_n)
      (!s_q.flags[`NIMS_BIT_TX_FAULT] && !tx_abort) |=> !s_q.flags[`NIMS_BIT_TX_FAULT];
  endproperty
  a_fault_clean: assert property (p_fault_clean) else $error("tx fault unprompted");

  property p_irq_drop;
    @(posedge mclk) disable iff (!reset_n)
      (irq && (s_d.flags & s_d.enables) == 16'h0000) |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq held too long");

  property p_enable_write;
    @(posedge mclk) disable iff (!reset_n)
      (wr_stb && wr_addr == `NIMS_ENABLE_OFFSET && wr_strb[1:0] == 2'b11)
      |=> s_q.enables == ($past(wr_data[15:0]) & 16'h7fff);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");
endmodule
`default_nettype wire

// ### testbench/nims_host_model.sv
// Host bus master model driving the interrupt registers
`timescale 1ns/1ps
`default_nettype none
module nims_host_model (
  input wire logic mclk,
  output var logic [7:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  output var logic [7:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
      output logic ok);
    ok = 1'b0;
    r = 2'b11;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge mclk);
      // Released address and data lines show the inverse, never a stale copy
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) begin
        r = bresp;
        ok = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
      output logic ok);
    ok = 1'b0;
    r = 2'b11;
    d = '0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        ok = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/test_nic_interrupt_mask_status.sv
// Self-checking bench for the interrupt flag and enable block
`timescale 1ns/1ps
`default_nettype none
`include "nims_params.svh"
module test_nic_interrupt_mask_status;
  localparam logic [7:0] flg_a = `NIMS_FLAG_OFFSET;
  localparam logic [7:0] en_a = `NIMS_ENABLE_OFFSET;
  localparam logic [7:0] cfg_a = `NIMS_CONFIG_OFFSET;
  localparam logic [7:0] st_a = `NIMS_STATE_OFFSET;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_master = 1'b0;
  logic [15:0] ev = '0;
  logic [5:0] cause = '0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, dma_hold, soft_reset;
  int fails = 0;
  int check_count = 0;
  always #2 mclk = ~mclk;
  nims_host_model host_u (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Event pulses share one vector; bit 13 ends a send, bit 15 is the beat
  nims_irq_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus_retry_input(ev[14]), .bus_master(bus_master), .tx_end(ev[13]),
    .collision_pulse(ev[15]), .filter_load_done(ev[12]), .tx_desc_request(ev[11]),
    .rx_seq_written(ev[10]), .tx_status_written(ev[9]), .tx_list_end(cause[0]),
    .tx_halted(cause[1]), .byte_total_mismatch(cause[2]), .too_many_collisions(cause[3]),
    .tx_fifo_underrun(cause[4]), .deferral_overlimit(cause[5]), .timer_wrap(ev[7]),
    .rx_desc_empty(ev[6]), .rx_resource_empty(ev[5]), .rx_area_end(ev[4]),
    .checksum_tally_wrap(ev[3]), .align_tally_wrap(ev[2]), .missed_tally_wrap(ev[1]),
    .rx_overflow(ev[0]), .irq(irq), .dma_hold(dma_hold), .soft_reset(soft_reset));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang();
    fails++;
    $display("[FAIL] %0t bus wait ran out", $time);
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'b00);
    logic [1:0] r;
    logic ok;
    host_u.axi_wr(a, {16'h0000, d}, r, ok);
    if (!ok) hang();
    chk(r, er, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'b00);
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    host_u.axi_rd(a, d, r, ok);
    if (!ok) hang();
    chk(r, er, "rresp");
    chk(d, {16'h0000, e}, "rdata");
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
  endtask
  task automatic t_events();
    int ids[12];
    logic [15:0] b;
    ids = '{14, 12, 11, 10, 7, 6, 5, 4, 3, 2, 1, 0};
    bus_master <= 1'b1;
    foreach (ids[k]) begin
      b = 16'h0001 << ids[k];
      pulse(ids[k]);
      idle(2);
      chk(irq, 1'b0, "masked irq");
      rd(flg_a, b);
      chk(dma_hold, 1'b0, "hold unlatched");
      wr(en_a, b);
      idle(1);
      chk(irq, 1'b1, "enabled irq");
      wr(flg_a, ~b & 16'h7fff);
      rd(flg_a, b);
      wr(flg_a, b);
      idle(1);
      chk(irq, 1'b0, "cleared irq");
      wr(en_a, 16'h0000);
    end
  endtask
  task automatic t_retry();
    wr(cfg_a, 16'h0001);
    bus_master <= 1'b0;
    pulse(14);
    rd(flg_a, 16'h0000);
    bus_master <= 1'b1;
    pulse(14);
    idle(20);
    chk(dma_hold, 1'b1, "retry hold");
    rd(st_a, 16'h0100);
    wr(flg_a, 16'h4000);
    idle(2);
    chk(dma_hold, 1'b0, "hold released");
    wr(cfg_a, 16'h0000);
    pulse(14);
    idle(2);
    chk(dma_hold, 1'b0, "no hold");
    rd(flg_a, 16'h4000);
    wr(flg_a, 16'h4000);
  endtask
  task automatic t_tx();
    wr(en_a, 16'h0100);
    // Causes: list end, halt, then the four abort reasons
    for (int c = 0; c < 6; c++) begin
      cause <= 6'd1 << c;
      idle(2);
      rd(flg_a, 16'h0000);
      pulse(9);
      cause <= '0;
      idle(2);
      chk(irq, c >= 2, "fault irq");
      rd(flg_a, (c < 2) ? 16'h0200 : 16'h0300);
      wr(flg_a, 16'h7fff);
    end
    rd(st_a, 16'h0008);
    wr(en_a, 16'h0000);
  endtask
  task automatic t_prio();
    fork
      wr(flg_a, 16'h0002);
      begin
        idle(2);
        ev[1] <= 1'b1;
        @(posedge mclk);
        ev[1] <= 1'b0;
      end
    join
    rd(flg_a, 16'h0002);
    wr(flg_a, 16'h0002);
    rd(flg_a, 16'h0000);
  endtask
  task automatic t_beat();
    wr(en_a, 16'h2000);
    pulse(13);
    idle(50);
    pulse(15);
    idle(1700);
    chk(irq, 1'b0, "beat seen");
    pulse(13);
    idle(1590);
    chk(irq, 1'b0, "early loss");
    idle(20);
    chk(irq, 1'b1, "beat lost");
    rd(flg_a, 16'h2000);
    wr(flg_a, 16'h2000);
  endtask
  task automatic t_resets();
    wr(en_a, 16'h0001);
    pulse(0);
    wr(cfg_a, 16'h0002);
    chk(soft_reset, 1'b1, "soft reset out");
    rd(flg_a, 16'h0001);
    rd(8'h40, 16'h0000, 2'b10);
    wr(8'h40, 16'h7fff, 2'b10);
    rd(en_a, 16'h0001);
    @(posedge mclk);
    reset_n <= 1'b0;
    idle(3);
    reset_n <= 1'b1;
    rd(flg_a, 16'h0000);
    rd(en_a, 16'h0000);
    chk(irq, 1'b0, "irq after reset");
    chk(soft_reset, 1'b0, "soft reset cleared");
  endtask
  task automatic t_mask();
    rd(flg_a, 16'h0000);
    rd(en_a, 16'h0000);
    rd(cfg_a, 16'h0000);
    wr(en_a, 16'hffff);
    rd(en_a, 16'h7fff);
    wr(en_a, 16'h0000);
  endtask
  initial begin
    idle(8);
    reset_n <= 1'b1;
    t_mask();
    $display("test reset_and_mask done");
    t_events();
    $display("test events done");
    t_retry();
    $display("test retry done");
    t_tx();
    $display("test transmit done");
    t_prio();
    $display("test priority done");
    t_beat();
    $display("test heartbeat done");
    t_resets();
    $display("test resets done");
    stop_test();
  end
endmodule
`default_nettype wire
